// ---- mss_monitor.sv ----
// monitor command interpreter with power-on security entry
`timescale 1ns/1ps
module mss_monitor #(
    parameter int BASE_BIT_CYCLES = mss_pkg::BIT_CYCLES_BASE
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic por_resetn_in,
    input wire logic divider_strap_pin_in,
    input wire logic [2:0] mult_n_in,
    input wire logic monitor_serial_pin_in,
    output logic monitor_serial_pin_out,
    output logic monitor_serial_pin_oe_out,
    output logic [15:0] mem_addr_out,
    output logic mem_rd_out,
    input wire logic [7:0] mem_rdata_in,
    output logic mem_wr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic exec_flash_in,
    output logic illegal_addr_reset_out,
    output logic flash_locked_out,
    output logic pull_index_high_out,
    output logic return_from_interrupt_out
);
    typedef enum {ST_ENTRY, ST_SEC_RX, ST_SEC_CMP, ST_READY, ST_CMD, ST_OPER,
        ST_RD_FETCH, ST_RD_WAIT, ST_RD_SEND, ST_RUN_PULL, ST_RUN_RTI} mss_st_e;
    mss_st_e state_ff;
    logic pin_meta_ff, pin_sync_ff, strap_meta_ff, strap_sync_ff;
    logic [1:0] cfg_cnt_ff;
    logic cfg_done_ff;
    logic [15:0] bit_cyc_ff;
    logic rx_valid, rx_break, tx_busy, tx_start;
    logic [7:0] rx_data;
    logic [11:0] tx_frame;
    logic [3:0] tx_bits;
    logic tried_ff, bypass_ff, sec_fail_ff, mismatch;
    logic [2:0] sec_idx_ff;
    logic [7:0] rx_byte_ff, rd_data_ff;
    logic [15:0] last_addr_ff;
    logic [1:0] oper_left_ff, rd_left_ff;
    logic rd_q_ff;

    // divisor per baud multiple k = N, doubled when the strap is low
    function automatic logic [15:0] bit_cycles(input logic [3:0] k);
        case (k)
            4'h2: bit_cycles = 16'(BASE_BIT_CYCLES / 2);
            4'h3: bit_cycles = 16'(BASE_BIT_CYCLES / 3);
            4'h4: bit_cycles = 16'(BASE_BIT_CYCLES / 4);
            4'h5: bit_cycles = 16'(BASE_BIT_CYCLES / 5);
            4'h6: bit_cycles = 16'(BASE_BIT_CYCLES / 6);
            4'h8: bit_cycles = 16'(BASE_BIT_CYCLES / 8);
            4'hA: bit_cycles = 16'(BASE_BIT_CYCLES / 10);
            4'hC: bit_cycles = 16'(BASE_BIT_CYCLES / 12);
            default: bit_cycles = 16'(BASE_BIT_CYCLES);
        endcase
    endfunction

    // flash reads return junk while security holds
    function automatic logic [7:0] read_gate(input logic [7:0] d,
            input logic [15:0] a, input logic locked);
        if (locked && a >= mss_pkg::FLASH_LO_ADDR) begin
            read_gate = mss_pkg::INVALID_BYTE;
        end else begin
            read_gate = d;
        end
    endfunction

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_meta_ff <= 1'b1;
            pin_sync_ff <= 1'b1;
            strap_meta_ff <= 1'b1;
            strap_sync_ff <= 1'b1;
        end else begin
            pin_meta_ff <= monitor_serial_pin_in;
            pin_sync_ff <= pin_meta_ff;
            strap_meta_ff <= divider_strap_pin_in;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // strap and multiplier caught once, just after reset release
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_cnt_ff <= 2'h0;
            cfg_done_ff <= 1'b0;
            bit_cyc_ff <= 16'(BASE_BIT_CYCLES);
        end else if (!cfg_done_ff) begin
            cfg_cnt_ff <= cfg_cnt_ff + 2'h1;
            if (cfg_cnt_ff == mss_pkg::CFG_SETTLE) begin
                cfg_done_ff <= 1'b1;
                bit_cyc_ff <= bit_cycles(strap_sync_ff ? {1'b0, mult_n_in}
                    : {mult_n_in, 1'b0});
            end
        end
    end

    mss_serial_phy u_phy (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .bit_cycles_in(bit_cyc_ff),
        .rx_in(pin_sync_ff),
        .tx_start_in(tx_start),
        .tx_frame_in(tx_frame),
        .tx_bits_in(tx_bits),
        .rx_valid_out(rx_valid),
        .rx_data_out(rx_data),
        .rx_break_out(rx_break),
        .tx_busy_out(tx_busy),
        .pin_out(monitor_serial_pin_out),
        .pin_oe_out(monitor_serial_pin_oe_out)
    );

    // echo outranks everything; results wait for the line to go quiet
    always_comb begin
        tx_start = 1'b0;
        tx_frame = 12'hFFF;
        tx_bits = 4'h0;
        if (rx_valid) begin
            tx_start = 1'b1;
            tx_frame = mss_pkg::byte_frame(rx_data);
            tx_bits = mss_pkg::BYTE_BITS;
        end else if (rx_break) begin
            tx_start = 1'b1;
            tx_frame = mss_pkg::BRK_ECHO_FRAME;
            tx_bits = mss_pkg::BRK_ECHO_BITS;
        end else if (state_ff == ST_READY && !tx_busy) begin
            tx_start = 1'b1;
            tx_frame = mss_pkg::READY_FRAME;
            tx_bits = mss_pkg::BYTE_BITS;
        end else if (state_ff == ST_RD_SEND && !tx_busy) begin
            tx_start = 1'b1;
            tx_frame = mss_pkg::byte_frame(rd_data_ff);
            tx_bits = mss_pkg::BYTE_BITS;
        end
    end

    // compares against live flash, so erased bytes match FF
    assign mismatch = (mem_rdata_in != rx_byte_ff);
    assign flash_locked_out = !bypass_ff;

    // power-on domain: survives every other reset
    always_ff @(posedge clk_in or negedge por_resetn_in) begin
        if (!por_resetn_in) begin
            tried_ff <= 1'b0;
            bypass_ff <= 1'b0;
        end else if (state_ff == ST_SEC_CMP && rd_q_ff
                && sec_idx_ff == mss_pkg::SEC_LAST_IDX) begin
            tried_ff <= 1'b1;
            bypass_ff <= !(sec_fail_ff || mismatch);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_q_ff <= 1'b0;
        end else begin
            rd_q_ff <= mem_rd_out;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= ST_ENTRY;
            sec_idx_ff <= 3'h0;
            sec_fail_ff <= 1'b0;
            rx_byte_ff <= 8'h00;
            rd_data_ff <= 8'h00;
            last_addr_ff <= mss_pkg::LAST_ADDR_RST;
            oper_left_ff <= 2'h0;
            rd_left_ff <= 2'h0;
            mem_addr_out <= 16'h0000;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_wdata_out <= 8'h00;
            pull_index_high_out <= 1'b0;
            return_from_interrupt_out <= 1'b0;
        end else begin
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            pull_index_high_out <= 1'b0;
            return_from_interrupt_out <= 1'b0;
            if (rx_break && state_ff != ST_SEC_RX && state_ff != ST_SEC_CMP
                    && state_ff != ST_ENTRY) begin
                state_ff <= ST_CMD;
            end else begin
                case (state_ff)
                    ST_ENTRY: begin
                        if (cfg_done_ff) begin
                            state_ff <= tried_ff ? ST_CMD : ST_SEC_RX;
                        end
                    end
                    ST_SEC_RX: begin
                        if (rx_valid) begin
                            rx_byte_ff <= rx_data;
                            mem_addr_out <= mss_pkg::SEC_BASE_ADDR
                                + {13'h0000, sec_idx_ff};
                            mem_rd_out <= 1'b1;
                            state_ff <= ST_SEC_CMP;
                        end
                    end
                    ST_SEC_CMP: begin
                        if (rd_q_ff) begin
                            sec_fail_ff <= sec_fail_ff || mismatch;
                            sec_idx_ff <= sec_idx_ff + 3'h1;
                            if (sec_idx_ff == mss_pkg::SEC_LAST_IDX) begin
                                mem_wr_out <= !(sec_fail_ff || mismatch);
                                mem_addr_out <= mss_pkg::SEC_FLAG_ADDR;
                                mem_wdata_out <= mss_pkg::SEC_FLAG_MASK;
                                state_ff <= ST_READY;
                            end else begin
                                state_ff <= ST_SEC_RX;
                            end
                        end
                    end
                    ST_READY: begin
                        if (tx_start) begin
                            state_ff <= ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        if (rx_valid && rx_data == mss_pkg::OP_INDEXED_READ_CMD) begin
                            oper_left_ff <= mss_pkg::INDEXED_READ_CMD_OPERANDS;
                            state_ff <= ST_OPER;
                        end else if (rx_valid && rx_data == mss_pkg::OP_RUN) begin
                            state_ff <= ST_RUN_PULL;
                        end
                    end
                    ST_OPER: begin
                        if (rx_valid) begin
                            oper_left_ff <= oper_left_ff - 2'h1;
                            if (oper_left_ff == 2'h1) begin
                                rd_left_ff <= mss_pkg::INDEXED_READ_CMD_RESULTS;
                                state_ff <= ST_RD_FETCH;
                            end
                        end
                    end
                    ST_RD_FETCH: begin
                        if (!tx_busy) begin
                            // wraps at the top of the 64K map
                            mem_addr_out <= last_addr_ff + 16'h0001;
                            last_addr_ff <= last_addr_ff + 16'h0001;
                            mem_rd_out <= 1'b1;
                            state_ff <= ST_RD_WAIT;
                        end
                    end
                    ST_RD_WAIT: begin
                        if (rd_q_ff) begin
                            rd_data_ff <= read_gate(mem_rdata_in,
                                mem_addr_out, !bypass_ff);
                            state_ff <= ST_RD_SEND;
                        end
                    end
                    ST_RD_SEND: begin
                        if (tx_start) begin
                            rd_left_ff <= rd_left_ff - 2'h1;
                            state_ff <= (rd_left_ff == 2'h1) ? ST_CMD
                                : ST_RD_FETCH;
                        end
                    end
                    ST_RUN_PULL: begin
                        if (!tx_busy) begin
                            pull_index_high_out <= 1'b1;
                            state_ff <= ST_RUN_RTI;
                        end
                    end
                    default: begin
                        return_from_interrupt_out <= 1'b1;
                        state_ff <= ST_CMD;
                    end
                endcase
            end
        end
    end

    // a locked part may not fetch from flash
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            illegal_addr_reset_out <= 1'b0;
        end else begin
            illegal_addr_reset_out <= exec_flash_in && !bypass_ff;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in || !por_resetn_in);

    a_echo_byte: assert property (rx_valid |-> tx_start
        && tx_frame == mss_pkg::byte_frame(rx_data))
        else $error("received byte not echoed");
    a_break_echo: assert property (rx_break |-> tx_start
        && tx_bits == mss_pkg::BRK_ECHO_BITS && tx_frame[1:0] == 2'b11)
        else $error("break echo lacks two high bits");
    a_ready_after: assert property ((tx_start
        && tx_frame == mss_pkg::READY_FRAME) |-> tried_ff)
        else $error("ready break before security bytes");
    a_run_order: assert property (pull_index_high_out
        |-> !tx_busy ##1 return_from_interrupt_out)
        else $error("run sequence out of order");
    a_bypass_sticky: assert property (bypass_ff |=> bypass_ff)
        else $error("bypass lost without power-on reset");
    a_locked_read: assert property ((state_ff == ST_RD_WAIT && rd_q_ff
        && !bypass_ff && mem_addr_out >= mss_pkg::FLASH_LO_ADDR)
        |=> rd_data_ff == mss_pkg::INVALID_BYTE)
        else $error("locked flash read leaked data");
    a_illegal_exec: assert property (exec_flash_in && !bypass_ff
        |=> illegal_addr_reset_out)
        else $error("locked flash fetch not reset");
    a_flag_write: assert property (mem_wr_out |-> bypass_ff
        && mem_addr_out == mss_pkg::SEC_FLAG_ADDR
        && mem_wdata_out == mss_pkg::SEC_FLAG_MASK)
        else $error("security flag write wrong");
    a_indexed_read_cmd_step: assert property ((state_ff == ST_RD_FETCH && !tx_busy
        && !rx_break) |=> mem_rd_out && mem_addr_out == last_addr_ff)
        else $error("indexed read not sequential");

    c_break_seen: cover property (rx_break);
    c_ready_sent: cover property (tx_start && tx_frame == mss_pkg::READY_FRAME);
    c_run_done: cover property (return_from_interrupt_out);
    c_indexed_read_cmd_done: cover property (state_ff == ST_RD_SEND && tx_start
        && rd_left_ff == 2'h1);
endmodule

// ---- mss_pkg.sv ----
// constants and helpers for the serial monitor and security block
package mss_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int BASE_BAUD = 4800;
    localparam int BIT_CYCLES_BASE = CLK_HZ / BASE_BAUD;
    localparam logic [7:0] OP_INDEXED_READ_CMD = 8'h1A;
    localparam logic [7:0] OP_RUN = 8'h28;
    localparam logic [15:0] SEC_BASE_ADDR = 16'hFFF6;
    localparam logic [2:0] SEC_LAST_IDX = 3'h7;
    localparam logic [15:0] SEC_FLAG_ADDR = 16'h0060;
    localparam logic [7:0] SEC_FLAG_MASK = 8'h40;
    localparam logic [15:0] FLASH_LO_ADDR = 16'h8000;
    localparam logic [7:0] INVALID_BYTE = 8'h00;
    localparam logic [15:0] LAST_ADDR_RST = 16'h0000;
    localparam logic [3:0] BYTE_BITS = 4'hA;
    localparam logic [3:0] BRK_ECHO_BITS = 4'hC;
    localparam logic [11:0] BRK_ECHO_FRAME = 12'h003;
    localparam logic [11:0] READY_FRAME = 12'hC00;
    localparam logic [1:0] INDEXED_READ_CMD_OPERANDS = 2'h2;
    localparam logic [1:0] INDEXED_READ_CMD_RESULTS = 2'h2;
    localparam logic [1:0] CFG_SETTLE = 2'h3;
    localparam logic [3:0] RX_LAST_BIT = 4'h9;

    // start low, data lsb first, stop high, then idle ones
    function automatic logic [11:0] byte_frame(input logic [7:0] d);
        byte_frame = {2'b11, 1'b1, d, 1'b0};
    endfunction
endpackage

// ---- mss_serial_phy.sv ----
// half-duplex nrz bit engine for the single monitor serial pin
`timescale 1ns/1ps
module mss_serial_phy (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [15:0] bit_cycles_in,
    input wire logic rx_in,
    input wire logic tx_start_in,
    input wire logic [11:0] tx_frame_in,
    input wire logic [3:0] tx_bits_in,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_break_out,
    output logic tx_busy_out,
    output logic pin_out,
    output logic pin_oe_out
);
    typedef enum {RX_IDLE, RX_BITS, RX_WAIT_HIGH} mss_rx_e;
    mss_rx_e rx_state_ff;
    logic [15:0] rx_cnt_ff;
    logic [3:0] rx_idx_ff;
    logic [8:0] rx_sh_ff;
    logic [8:0] nxt_rx_sh;
    logic [11:0] tx_sh_ff;
    logic [3:0] tx_left_ff;
    logic [15:0] tx_cnt_ff;
    logic [1:0] tx_hist_ff;

    assign nxt_rx_sh = {rx_in, rx_sh_ff[8:1]};
    assign tx_busy_out = (tx_left_ff != 4'h0);
    assign pin_out = tx_sh_ff[0];
    assign pin_oe_out = tx_busy_out;

    // the synchroniser still shows our last driven bit for two cycles
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_hist_ff <= 2'h0;
        end else begin
            tx_hist_ff <= {tx_hist_ff[0], tx_busy_out};
        end
    end

    // receiver ignores the pin while we drive it, so our own echo is unseen
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff <= 16'h0000;
            rx_idx_ff <= 4'h0;
            rx_sh_ff <= 9'h000;
            rx_valid_out <= 1'b0;
            rx_break_out <= 1'b0;
            rx_data_out <= 8'h00;
        end else begin
            rx_valid_out <= 1'b0;
            rx_break_out <= 1'b0;
            case (rx_state_ff)
                RX_IDLE: begin
                    if (!tx_busy_out && tx_hist_ff == 2'h0 && !rx_in) begin
                        rx_cnt_ff <= {1'b0, bit_cycles_in[15:1]};
                        rx_idx_ff <= 4'h0;
                        rx_state_ff <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (rx_cnt_ff != 16'h0000) begin
                        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                    end else begin
                        rx_cnt_ff <= bit_cycles_in - 16'h0001;
                        if (rx_idx_ff == 4'h0) begin
                            // a start bit gone high by mid-bit was a glitch
                            rx_state_ff <= rx_in ? RX_IDLE : RX_BITS;
                            rx_idx_ff <= 4'h1;
                        end else begin
                            rx_sh_ff <= nxt_rx_sh;
                            rx_idx_ff <= rx_idx_ff + 4'h1;
                            if (rx_idx_ff == mss_pkg::RX_LAST_BIT) begin
                                if (nxt_rx_sh[8]) begin
                                    rx_valid_out <= 1'b1;
                                    rx_data_out <= nxt_rx_sh[7:0];
                                    rx_state_ff <= RX_IDLE;
                                end else begin
                                    // start plus nine lows
                                    rx_break_out <= (nxt_rx_sh[7:0] == 8'h00);
                                    rx_state_ff <= RX_WAIT_HIGH;
                                end
                            end
                        end
                    end
                end
                default: begin
                    if (rx_in) begin
                        rx_state_ff <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ones shift in behind the frame so the pin idles at mark
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_sh_ff <= 12'hFFF;
            tx_left_ff <= 4'h0;
            tx_cnt_ff <= 16'h0000;
        end else if (tx_start_in && !tx_busy_out) begin
            tx_sh_ff <= tx_frame_in;
            tx_left_ff <= tx_bits_in;
            tx_cnt_ff <= bit_cycles_in - 16'h0001;
        end else if (tx_busy_out) begin
            if (tx_cnt_ff == 16'h0000) begin
                tx_sh_ff <= {1'b1, tx_sh_ff[11:1]};
                tx_left_ff <= tx_left_ff - 4'h1;
                tx_cnt_ff <= bit_cycles_in - 16'h0001;
            end else begin
                tx_cnt_ff <= tx_cnt_ff - 16'h0001;
            end
        end
    end
endmodule

// ---- mss_host.sv ----
// host model for the single-pin monitor serial link
`timescale 1ns/1ps
module mss_host (
    input wire logic clk_in,
    input wire logic [15:0] bit_cycles_in,
    input wire logic line_in,
    output logic tx_out
);
    initial tx_out = 1'b1;
    // a gap first, since a start bit during the echo is ignored
    task automatic send(input logic [7:0] d, input logic stop_bit);
        logic [9:0] f;
        f = {stop_bit, d, 1'b0};
        repeat (bit_cycles_in) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            tx_out <= f[i];
            repeat (i == 9 ? bit_cycles_in / 2 : bit_cycles_in) @(posedge clk_in);
        end
        // a break is held low until the device takes the line
        for (int n = 0; n < 4000 && line_in !== 1'b1; n++) @(posedge clk_in);
        tx_out <= 1'b1;
    endtask
    // returns at mid stop bit, with the cycles spent waiting for start
    task automatic recv(output logic [7:0] d, output logic s, output int w);
        logic [9:0] f;
        for (w = 0; w < 4000 && line_in === 1'b1; w++) @(posedge clk_in);
        repeat (bit_cycles_in / 2) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            f[i] = line_in;
            if (i < 9) repeat (bit_cycles_in) @(posedge clk_in);
        end
        d = f[8:1];
        s = f[9];
    endtask
endmodule

// ---- monitor_serial_security_test.sv ----
// testbench for the serial monitor and security entry
`timescale 1ns/1ps
module monitor_serial_security_test;
    logic clk_in = 1'b0, resetn_in = 1'b0, por_resetn_in = 1'b0;
    logic strap = 1'b1, exec_flash = 1'b0, host_tx, pin, oe, line;
    logic [15:0] addr, host_bits = 16'h0030;
    logic [2:0] mult = 3'h1;
    logic rd, wr, locked, illegal, pull_h, return_from_interrupt;
    logic [7:0] rdata = 8'h00, wdata, mem [0:65535];
    int bad_count = 0, checks_done = 0;
    assign line = oe ? pin : host_tx;
    always #20 clk_in = ~clk_in;
    mss_monitor #(.BASE_BIT_CYCLES(48)) i_dut (.clk_in(clk_in),
        .resetn_in(resetn_in), .por_resetn_in(por_resetn_in),
        .divider_strap_pin_in(strap), .mult_n_in(mult),
        .monitor_serial_pin_in(line), .monitor_serial_pin_out(pin),
        .monitor_serial_pin_oe_out(oe), .mem_addr_out(addr),
        .mem_rd_out(rd), .mem_rdata_in(rdata), .mem_wr_out(wr),
        .mem_wdata_out(wdata), .exec_flash_in(exec_flash),
        .illegal_addr_reset_out(illegal), .flash_locked_out(locked),
        .pull_index_high_out(pull_h), .return_from_interrupt_out(return_from_interrupt));
    mss_host i_host (.clk_in(clk_in), .bit_cycles_in(host_bits),
        .line_in(line), .tx_out(host_tx));
    // data one cycle after the read strobe
    always @(posedge clk_in) begin
        if (rd) rdata <= mem[addr];
        if (wr) mem[addr] <= wdata;
    end
    task automatic check(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic [7:0] d);
        logic [7:0] r;
        logic s;
        int w;
        i_host.send(d, 1'b1);
        i_host.recv(r, s, w);
        check("echo", {8'h00, d}, {8'h00, r});
    endtask
    task automatic do_reset(input logic por, input logic strap_lvl);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        por_resetn_in <= ~por;
        strap <= strap_lvl;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        por_resetn_in <= 1'b1;
        repeat (10) @(posedge clk_in);
    endtask
    task automatic test_entry(input logic good);
        logic [7:0] r;
        logic s;
        int w;
        for (int i = 0; i < 8; i++) xfer(mem[16'hFFF6 + i] ^ {8{~good}});
        i_host.recv(r, s, w);
        check("ready break", 16'h0000, {7'h00, s, r});
        check("locked", {15'h0000, ~good}, {15'h0000, locked});
        if (good) check("flag", 16'h0040, {8'h00, mem[16'h0060]});
        $display("entry test done");
    endtask
    task automatic test_indexed_read_cmd(input logic [15:0] base);
        logic [7:0] r;
        logic s;
        int w;
        xfer(8'h1A);
        xfer(8'h12);
        xfer(8'h34);
        for (int i = 1; i < 3; i++) begin
            i_host.recv(r, s, w);
            check("read data", {8'h00, mem[base + i]}, {8'h00, r});
        end
        $display("indexed read test done");
    endtask
    task automatic test_break();
        logic [7:0] r;
        logic s;
        int w;
        i_host.send(8'h00, 1'b0);
        i_host.recv(r, s, w);
        check("break echo", 16'h0000, {7'h00, s, r});
        check("high span", 16'h0001, 16'(w > 2 * host_bits - 6 && w < 2 * host_bits + 2));
        $display("break test done");
    endtask
    task automatic test_run();
        int n;
        xfer(8'h28);
        for (n = 0; n < 200 && pull_h !== 1'b1; n++) @(posedge clk_in) #1;
        check("pull index high", 16'h0001, {15'h0000, pull_h});
        @(posedge clk_in) #1;
        check("return", 16'h0001, {15'h0000, return_from_interrupt});
        $display("run test done");
    endtask
    task automatic test_illegal();
        @(posedge clk_in);
        exec_flash <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1 check("illegal reset", 16'h0001, {15'h0000, illegal});
        exec_flash <= 1'b0;
        $display("illegal fetch test done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h5A;
        do_reset(1'b1, 1'b1);
        test_entry(1'b1);
        test_indexed_read_cmd(16'h0000);
        test_indexed_read_cmd(16'h0002);
        test_break();
        test_run();
        do_reset(1'b0, 1'b1);
        check("bypass kept", 16'h0000, {15'h0000, locked});
        test_indexed_read_cmd(16'h0000);
        host_bits = 16'h000C;
        mult <= 3'h2;
        do_reset(1'b1, 1'b0);
        test_entry(1'b0);
        test_illegal();
        stop_test();
    end
    // the sequence needs roughly 24000 cycles
    initial begin
        repeat (95000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end
endmodule
